// [core/ecl_loader.v]
// configuration store loader: apb registers, program walker and store/bank sequencer
`timescale 1ns/100ps
`include "ecl_regs.vh"

module ecl_loader #(
  parameter EE_AW    = 10,
  parameter SEG_LEN  = `ECL_SEG_LEN,
  parameter [8*`ECL_SEG_LEN-1:0] DEF_PROG = `ECL_DEF_PROG
) (
  input  wire             sys_clk,
  input  wire             nrst,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [15:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output reg              pslverr,
  input  wire             store_sel,
  input  wire             mirror_sel,
  input  wire             status_alt_src,
  output wire             first_status_output_pin,
  output wire             irq,
  output reg  [11:0]      cfg_addr_r,
  output reg  [7:0]       cfg_wdata_r,
  output reg              cfg_we_r,
  input  wire [7:0]       cfg_rdata,
  output reg              apply_settings_r,
  output reg              soft_reset_r,
  output reg              ee_req_r,
  output reg              ee_we_r,
  output reg  [EE_AW-1:0] ee_addr_r,
  output reg  [7:0]       ee_wdata_r,
  input  wire             ee_ack,
  input  wire [7:0]       ee_rdata
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_FETCH  = 3'h1;
  localparam [2:0] ST_XADR   = 3'h2;
  localparam [2:0] ST_XGO    = 3'h3;
  localparam [2:0] ST_XWAIT  = 3'h4;
  localparam [2:0] ST_CKGO   = 3'h5;
  localparam [2:0] ST_CKWAIT = 3'h6;
  localparam [2:0] ST_FINISH = 3'h7;

  reg  [7:0]       seg_r [0:SEG_LEN-1];
  reg  [2:0]       st_r;
  reg  [4:0]       pc_r;
  reg  [7:0]       cnt_r;
  reg  [11:0]      addr_r;
  reg  [EE_AW-1:0] eptr_r;
  reg  [7:0]       sum_r;
  reg              dir_store_r;
  reg              wr_en_r;
  reg              soft_r;
  reg              trig_r;
  reg              err_r;
  reg  [1:0]       irq_stat_r;
  reg  [1:0]       irq_mask_r;
  reg  [1:0]       irq_set;

  wire [13:0]      idx      = paddr[15:2];
  wire             wr_acc   = psel & penable & pwrite;
  wire             rd_acc   = psel & penable & ~pwrite;
  wire             busy     = (st_r != ST_IDLE);
  wire             seg_hit  = (idx >= `ECL_IDX_SEG_FIRST) && (idx <= `ECL_IDX_SEG_LAST);
  wire [4:0]       seg_off  = idx[4:0];
  wire             mapped   = seg_hit || ((idx >= `ECL_IDX_PENDING) && (idx <= `ECL_IDX_IRQ_MASK));
  wire [7:0]       op       = (pc_r < SEG_LEN) ? seg_r[pc_r] : `ECL_OP_END;
  wire [7:0]       op_hi    = (pc_r + 5'd1 < SEG_LEN) ? seg_r[pc_r + 5'd1] : 8'h00;
  wire [7:0]       op_lo    = (pc_r + 5'd2 < SEG_LEN) ? seg_r[pc_r + 5'd2] : 8'h00;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign irq    = |(irq_stat_r & irq_mask_r);
  assign first_status_output_pin = mirror_sel ? busy : status_alt_src;

  // program segment, reloaded with the default program at reset; frozen while a job walks it
  genvar gi;
  generate
    for (gi = 0; gi < SEG_LEN; gi = gi + 1) begin : g_seg
      always @(posedge sys_clk) begin
        if (!nrst) begin
          seg_r[gi] <= DEF_PROG[8*gi +: 8];
        end else if (wr_acc && seg_hit && !busy && seg_off == gi) begin
          seg_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // read mux and error answer
  always @* begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      if (!mapped) begin
        pslverr = 1'b1;
      end else if (seg_hit) begin
        prdata[7:0] = seg_r[seg_off];
        pslverr     = pwrite & busy;
      end else begin
        case (idx)
          `ECL_IDX_PENDING:  prdata[0]   = busy;
          `ECL_IDX_ERROR:    prdata[0]   = err_r;
          `ECL_IDX_CTL_ONE:  prdata[1:0] = {soft_r, wr_en_r};
          `ECL_IDX_CTL_TWO:  prdata[0]   = trig_r;
          `ECL_IDX_IRQ_STAT: prdata[1:0] = irq_stat_r;
          `ECL_IDX_IRQ_MASK: prdata[1:0] = irq_mask_r;
          default:           prdata      = 32'h0000_0000;
        endcase
      end
    end
  end

  // control bits; job start requests are only accepted while idle
  always @(posedge sys_clk) begin
    if (!nrst) begin
      wr_en_r    <= 1'b0;
      soft_r     <= 1'b0;
      trig_r     <= 1'b0;
      irq_mask_r <= 2'b00;
      irq_stat_r <= 2'b00;
    end else begin
      if (wr_acc && idx == `ECL_IDX_CTL_ONE) begin
        wr_en_r <= pwdata[`ECL_BIT_WR_EN];
        if (pwdata[`ECL_BIT_SOFT] && !store_sel && !busy && !trig_r) begin
          soft_r <= 1'b1;
        end
      end
      // store request with protection on is dropped and the trigger stays clear
      if (wr_acc && idx == `ECL_IDX_CTL_TWO && pwdata[`ECL_BIT_TRIG] && wr_en_r && !busy && !soft_r) begin
        trig_r <= 1'b1;
      end
      if (st_r == ST_FINISH) begin
        if (dir_store_r) begin
          trig_r <= 1'b0;
        end else begin
          soft_r <= 1'b0;
        end
      end
      if (wr_acc && idx == `ECL_IDX_IRQ_MASK) begin
        irq_mask_r <= pwdata[1:0];
      end
      // set wins over a same-cycle write-one-to-clear
      if (wr_acc && idx == `ECL_IDX_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  always @* begin
    irq_set = 2'b00;
    if (st_r == ST_FINISH) begin
      irq_set[`ECL_IRQ_DONE] = 1'b1;
      irq_set[`ECL_IRQ_ERR]  = err_r;
    end
  end

  // program walker and byte mover
  always @(posedge sys_clk) begin
    if (!nrst) begin
      st_r             <= ST_IDLE;
      pc_r             <= 5'd0;
      cnt_r            <= 8'h00;
      addr_r           <= 12'h000;
      eptr_r           <= {EE_AW{1'b0}};
      sum_r            <= `ECL_SUM_INIT;
      dir_store_r      <= 1'b0;
      err_r            <= 1'b0;
      cfg_addr_r       <= 12'h000;
      cfg_wdata_r      <= 8'h00;
      cfg_we_r         <= 1'b0;
      apply_settings_r <= 1'b0;
      soft_reset_r     <= 1'b0;
      ee_req_r         <= 1'b0;
      ee_we_r          <= 1'b0;
      ee_addr_r        <= {EE_AW{1'b0}};
      ee_wdata_r       <= 8'h00;
    end else begin
      cfg_we_r         <= 1'b0;
      apply_settings_r <= 1'b0;
      soft_reset_r     <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          pc_r   <= 5'd0;
          eptr_r <= {EE_AW{1'b0}};
          sum_r  <= `ECL_SUM_INIT;
          if (trig_r) begin
            dir_store_r <= 1'b1;
            err_r       <= 1'b0;
            st_r        <= ST_FETCH;
          end else if (soft_r) begin
            dir_store_r  <= 1'b0;
            err_r        <= 1'b0;
            soft_reset_r <= 1'b1;
            st_r         <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (op == `ECL_OP_END) begin
            st_r <= ST_CKGO;
          end else if (op == `ECL_OP_APPLY) begin
            // only a reload has fresh buffered values worth applying
            apply_settings_r <= ~dir_store_r;
            pc_r             <= pc_r + 5'd1;
          end else if (!op[7]) begin
            cnt_r  <= {1'b0, op[6:0]} + 8'h01;
            addr_r <= {op_hi[3:0], op_lo};
            pc_r   <= pc_r + 5'd3;
            st_r   <= ST_XADR;
          end else begin
            // unknown code: skipped so a bad program cannot hang the walker
            pc_r <= pc_r + 5'd1;
          end
        end
        ST_XADR: begin
          cfg_addr_r <= addr_r;
          st_r       <= ST_XGO;
        end
        ST_XGO: begin
          ee_req_r   <= 1'b1;
          ee_we_r    <= dir_store_r & wr_en_r;
          ee_addr_r  <= eptr_r;
          ee_wdata_r <= cfg_rdata;
          if (dir_store_r) begin
            sum_r <= sum_r + cfg_rdata;
          end
          st_r <= ST_XWAIT;
        end
        ST_XWAIT: begin
          if (ee_ack) begin
            ee_req_r <= 1'b0;
            ee_we_r  <= 1'b0;
            eptr_r   <= eptr_r + {{(EE_AW-1){1'b0}}, 1'b1};
            addr_r   <= addr_r + 12'h001;
            cnt_r    <= cnt_r - 8'h01;
            if (!dir_store_r) begin
              cfg_wdata_r <= ee_rdata;
              cfg_we_r    <= 1'b1;
              sum_r       <= sum_r + ee_rdata;
            end
            st_r <= (cnt_r == 8'h01) ? ST_FETCH : ST_XADR;
          end
        end
        ST_CKGO: begin
          ee_req_r   <= 1'b1;
          ee_we_r    <= dir_store_r & wr_en_r;
          ee_addr_r  <= eptr_r;
          ee_wdata_r <= sum_r;
          st_r       <= ST_CKWAIT;
        end
        ST_CKWAIT: begin
          if (ee_ack) begin
            ee_req_r <= 1'b0;
            ee_we_r  <= 1'b0;
            if (!dir_store_r) begin
              err_r <= (ee_rdata != sum_r);
            end
            st_r <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [pkg/ecl_regs.vh]
// register indices, field positions, opcodes and reset values of the configuration store loader
`ifndef ECL_REGS_VH
`define ECL_REGS_VH

`define ECL_IDX_SEG_FIRST 14'ha00
`define ECL_IDX_SEG_LAST  14'ha16
`define ECL_IDX_PENDING   14'hb00
`define ECL_IDX_ERROR     14'hb01
`define ECL_IDX_CTL_ONE   14'hb02
`define ECL_IDX_CTL_TWO   14'hb03
`define ECL_IDX_IRQ_STAT  14'hb04
`define ECL_IDX_IRQ_MASK  14'hb05

`define ECL_SEG_LEN       23

`define ECL_BIT_WR_EN     0
`define ECL_BIT_SOFT      1
`define ECL_BIT_TRIG      0
`define ECL_IRQ_DONE      0
`define ECL_IRQ_ERR       1

`define ECL_OP_APPLY      8'h80
`define ECL_OP_END        8'hff

`define ECL_SUM_INIT      8'h5a

// default program: five 128-byte ranges from 0x000, apply-settings, end, padding with end
`define ECL_DEF_PROG {{6{8'hff}}, 8'hff, 8'h80, \
  8'h00, 8'h02, 8'h7f, 8'h80, 8'h01, 8'h7f, 8'h00, 8'h01, 8'h7f, \
  8'h80, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h7f}

`endif

// [verification/ecl_loader_checker.sv]
// port assertions for the configuration store loader
`timescale 1ns/100ps
module ecl_loader_checker (
  input wire        sys_clk,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire        store_sel,
  input wire        mirror_sel,
  input wire        status_alt_src,
  input wire        first_status_output_pin,
  input wire        ee_req_r,
  input wire        ee_we_r,
  input wire        ee_ack,
  input wire        cfg_we_r,
  input wire        apply_settings_r,
  input wire        soft_reset_r
);
  logic wen_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_acc(a, b);
    psel && penable && pwrite && paddr == a && pwdata[b];
  endsequence
  // idle only visible through the pin while mirrored
  sequence s_idle;
    mirror_sel && !first_status_output_pin;
  endsequence
  always @(posedge sys_clk) begin
    if (!nrst)
      wen_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == 16'h2c08)
      wen_r <= pwdata[0];
  end
  a_pin_alt: assert property (!mirror_sel |-> first_status_output_pin == status_alt_src) else $error("pin alt");
  a_pin_busy: assert property (mirror_sel && ee_req_r |-> first_status_output_pin) else $error("pin busy");
  a_trig_start: assert property (s_acc(16'h2c0c, 0) ##0 s_idle ##0 wen_r |-> ##[1:6] (ee_req_r && ee_we_r))
    else $error("store not started");
  a_wp_guard: assert property (ee_req_r && ee_we_r |-> wen_r) else $error("write while protected");
  a_wp_ignore: assert property (s_acc(16'h2c0c, 0) ##0 s_idle ##0 !wen_r |=> !ee_req_r [*4])
    else $error("protected store ran");
  a_soft_start: assert property (s_acc(16'h2c08, 1) ##0 s_idle ##0 !store_sel |-> ##[1:4] soft_reset_r)
    else $error("reload not started");
  a_soft_refuse: assert property (s_acc(16'h2c08, 1) ##0 store_sel |=> !soft_reset_r [*4])
    else $error("reload with select high");
  a_bank_write: assert property (cfg_we_r |-> $past(ee_ack) && !ee_we_r) else $error("bank write");
  a_apply_once: assert property (apply_settings_r |=> !apply_settings_r) else $error("apply");
endmodule
bind ecl_loader ecl_loader_checker chk (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .store_sel,
  .mirror_sel, .status_alt_src, .first_status_output_pin, .ee_req_r, .ee_we_r, .ee_ack, .cfg_we_r,
  .apply_settings_r, .soft_reset_r);

// [verification/ecl_store_model.sv]
// behavioural nonvolatile byte store answering the loader's requests
`timescale 1ns/100ps
module ecl_store_model #(
  parameter DLY = 1
) (
  input  wire         sys_clk,
  input  wire         ee_req_r,
  input  wire         ee_we_r,
  input  wire [9:0]   ee_addr_r,
  input  wire [7:0]   ee_wdata_r,
  input  wire         bad,
  output logic        ee_ack = 0,
  output logic [7:0]  ee_rdata,
  output logic [15:0] wr_n = 0
);
  logic [7:0] mem [0:1023];
  logic [7:0] q = 0;
  int         cnt = 0;
  // data only valid with ack; the inverse otherwise, so a late sample shows
  assign ee_rdata = ee_ack ? q : ~q;
  always @(posedge sys_clk) begin
    ee_ack <= 1'b0;
    if (!ee_req_r || ee_ack)
      cnt <= 0;
    else if (cnt >= DLY + ee_addr_r[0]) begin
      ee_ack <= 1'b1;
      cnt    <= 0;
      q      <= mem[ee_addr_r] ^ {7'h0, bad};
      if (ee_we_r) begin
        mem[ee_addr_r] <= ee_wdata_r;
        wr_n           <= wr_n + 16'h1;
      end
    end else
      cnt <= cnt + 1;
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the configuration store loader
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb;
  logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, store_sel = 1, bad = 0;
  logic        mirror_sel = 1, status_alt_src = 0, srst;
  logic [15:0] paddr = 0, wr_n;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, err, pin, irq, cfg_we_r, apply, ee_req_r, ee_we_r, ee_ack;
  logic [11:0] cfg_addr_r;
  logic [7:0]  cfg_wdata_r, ee_wdata_r, ee_rdata;
  logic [9:0]  ee_addr_r;
  int          fails = 0, n_tests = 0, n_apply = 0, n_srst = 0;
  always #25 sys_clk = ~sys_clk;
  ecl_loader uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .store_sel, .mirror_sel, .status_alt_src, .first_status_output_pin(pin), .irq, .cfg_addr_r,
    .cfg_wdata_r, .cfg_we_r, .cfg_rdata(cfg_addr_r[7:0] ^ 8'h3c), .apply_settings_r(apply), .soft_reset_r(srst),
    .ee_req_r, .ee_we_r, .ee_addr_r, .ee_wdata_r, .ee_ack, .ee_rdata);
  ecl_store_model #(.DLY(1)) stm (.sys_clk, .ee_req_r, .ee_we_r, .ee_addr_r, .ee_wdata_r, .bad, .ee_ack,
    .ee_rdata, .wr_n);
  always @(posedge sys_clk) begin
    if (apply === 1'b1) n_apply++;
    if (srst === 1'b1) n_srst++;
    if (cfg_we_r === 1'b1 && !bad) `CHK(cfg_wdata_r, cfg_addr_r[7:0] ^ 8'h3c)
  end
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // software side: poll pending with a bound
  task automatic wait_idle;
    int i;
    i = 0;
    do begin apb(0, 16'h2c00, 0); i++; end while (q[0] !== 1'b0 && i < 9000);
    if (i >= 9000) fails++;
  endtask
  task automatic t_reset;
    apb(0, 16'h2c08, 0); `CHK(q, 32'h0)
    apb(0, 16'h2c00, 0); `CHK(q, 32'h0)
    apb(0, 16'h2800, 0); `CHK(q, 32'h7f)
    apb(1, 16'h2858, 32'hff); apb(0, 16'h2858, 0); `CHK(q, 32'hff)
    apb(0, 16'h3000, 0); `CHK({err, q}, 33'h100000000)
    apb(1, 16'h2c0c, 1); apb(0, 16'h2c0c, 0); `CHK(q, 32'h0)
    `CHK(wr_n, 16'h0)
    @(posedge sys_clk);
    mirror_sel <= 0; status_alt_src <= 1;
    @(negedge sys_clk); `CHK(pin, 1'b1)
    @(posedge sys_clk);
    mirror_sel <= 1; status_alt_src <= 0;
    @(negedge sys_clk); `CHK(pin, 1'b0)
  endtask
  task automatic t_store;
    apb(1, 16'h2c08, 1); apb(1, 16'h2c0c, 1); apb(0, 16'h2c0c, 0); `CHK(q, 32'h1)
    `CHK(pin, 1'b1)
    apb(1, 16'h2800, 0); `CHK(err, 1'b1)
    wait_idle;
    apb(0, 16'h2c0c, 0); `CHK(q, 32'h0)
    `CHK(wr_n, 16'd641)
    @(negedge sys_clk); `CHK(irq, 1'b0)
    apb(1, 16'h2c14, 3); @(negedge sys_clk); `CHK(irq, 1'b1)
    apb(1, 16'h2c10, 3); @(negedge sys_clk); `CHK(irq, 1'b0)
  endtask
  // a corrupted read must raise the error flag
  task automatic t_reload(input logic b);
    @(posedge sys_clk);
    bad <= b; store_sel <= 1;
    apb(1, 16'h2c08, 3); apb(0, 16'h2c00, 0); `CHK(q, 32'h0)
    @(posedge sys_clk);
    store_sel <= 0; n_apply = 0; n_srst = 0;
    apb(1, 16'h2c08, 2); wait_idle;
    `CHK(n_apply, 1)
    `CHK(n_srst, 1)
    apb(0, 16'h2c08, 0); `CHK(q, 32'h0)
    apb(0, 16'h2c04, 0); `CHK(q, {31'h0, b})
  endtask
  task close_out;
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1;
    t_reset;
    t_store;
    t_reload(0);
    t_reload(1);
    close_out;
  end
  initial begin
    repeat (80000) @(posedge sys_clk);
    fails++;
    close_out;
  end
endmodule
